//--- hw/led_fault_status_flags.sv
// Fault status register bank of a multi-channel LED driver, on APB.
//
// Overview of operation
// RULE1: short flags H2..H0 bits 6-4, G2..G0 bits 2-0
// RULE2: short flag one when fault detected, else zero
// RULE3: open byte A/B at 0xA7, reset zero
// RULE4: B2..B0 bits 6-4, A2..A0 bits 2-0
// RULE5: open flag zero until fault, one when detected
// RULE6: open byte C/D at 0xA8, reset zero
// RULE7: flags and reserved bits read-only, reset zero
// RULE8: short byte G/H at 0xA6, reset zero
// RULE9: D2..D0 bits 6-4, C2..C0 bits 2-0
// RULE10: writes to status bytes change nothing
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module led_fault_status_flags (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fault_flags_pkg::ADDR_W-1:0] paddr,
  input wire logic [fault_flags_pkg::DATA_W-1:0] pwdata,
  output logic [fault_flags_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw detector levels: short H2..H0,G2..G0; open D..C..B..A, 2..0 each.
  input wire logic [fault_flags_pkg::N_SHORT-1:0] short_detect,
  input wire logic [fault_flags_pkg::N_OPEN-1:0] open_detect,
  // Interrupt.
  output logic irq
);
  localparam int NE = fault_flags_pkg::N_EVENTS;
  localparam int G = fault_flags_pkg::CH_PER_GROUP;
  localparam int LO = fault_flags_pkg::LOW_GROUP_LSB;
  localparam int HI = fault_flags_pkg::HIGH_GROUP_LSB;

  ////////////////////////////////////////////////////////////////////////////
  // Detector inputs.

  fault_level_if #(.N(NE)) flt ();
  logic [NE-1:0] irq_status;
  logic irq_q;

  fault_sync #(.N(NE)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .raw({open_detect, short_detect}),
    .out(flt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status bytes, built from live levels; reserved bits stay zero.

  logic [7:0] short_gh, open_ab, open_cd;
  logic [NE-1:0] lvl;

  assign lvl = flt.level;

  always_comb begin
    short_gh = fault_flags_pkg::FLAG_BYTE_RESET; // RULE7
    open_ab = fault_flags_pkg::FLAG_BYTE_RESET; // RULE7
    open_cd = fault_flags_pkg::FLAG_BYTE_RESET; // RULE7
    // Flag follows the detector: one while detected, zero otherwise.
    short_gh[HI +: G] = lvl[G +: G]; // RULE1 RULE2
    short_gh[LO +: G] = lvl[0 +: G]; // RULE1 RULE2
    open_ab[HI +: G] = lvl[3*G +: G]; // RULE4 RULE5
    open_ab[LO +: G] = lvl[2*G +: G]; // RULE4 RULE5
    open_cd[HI +: G] = lvl[5*G +: G]; // RULE9 RULE5
    open_cd[LO +: G] = lvl[4*G +: G]; // RULE9 RULE5
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered.

  logic [fault_flags_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [NE-1:0] mask_q, mask_d;
  logic rd_clear;
  logic access;

  function automatic logic [fault_flags_pkg::ADDR_W-1:0] byte_addr(
    input logic [9:0] idx
  );
    byte_addr = {idx, 2'b00};
  endfunction

  assign access = psel & penable & ~pready_q;

  always_comb begin
    prdata_d = fault_flags_pkg::RDATA_RESET;
    pready_d = access;
    pslverr_d = 1'b0;
    mask_d = mask_q;
    rd_clear = 1'b0;
    if (access) begin
      if (paddr == byte_addr(fault_flags_pkg::IDX_SHORT_GH)) begin // RULE8
        prdata_d[7:0] = short_gh; // RULE10
      end else if (paddr == byte_addr(fault_flags_pkg::IDX_OPEN_AB)) begin
        prdata_d[7:0] = open_ab; // RULE3 RULE10
      end else if (paddr == byte_addr(fault_flags_pkg::IDX_OPEN_CD)) begin
        prdata_d[7:0] = open_cd; // RULE6 RULE10
      end else if (paddr == byte_addr(fault_flags_pkg::IDX_IRQ_STATUS)) begin
        prdata_d[NE-1:0] = irq_status;
        rd_clear = ~pwrite;
      end else if (paddr == byte_addr(fault_flags_pkg::IDX_IRQ_MASK)) begin
        prdata_d[NE-1:0] = mask_q;
        if (pwrite) begin
          mask_d = pwdata[NE-1:0];
        end
      end else begin
        pslverr_d = 1'b1;
      end
      if (pwrite) begin
        prdata_d = fault_flags_pkg::RDATA_RESET;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_q <= fault_flags_pkg::RDATA_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mask_q <= fault_flags_pkg::IRQ_MASK_RESET;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      mask_q <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: each new fault sets a sticky bit; reading status clears it.

  fault_irq #(.N(NE)) u_irq (
    .mclk(mclk),
    .rst(rst),
    .set(flt.rise),
    .mask(mask_q),
    .clear(rd_clear),
    .status_q(irq_status),
    .irq_q(irq_q)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
endmodule

//--- hw/fault_flags_pkg.sv
// Package with register map, field layout and reset values of the fault flags.
package fault_flags_pkg;
  // Printed register offsets are register indices; byte address is 4x.
  localparam logic [9:0] IDX_SHORT_GH = 10'h0A6;
  localparam logic [9:0] IDX_OPEN_AB = 10'h0A7;
  localparam logic [9:0] IDX_OPEN_CD = 10'h0A8;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0B0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0B1;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Three channels per group, two groups per byte.
  localparam int CH_PER_GROUP = 3;
  localparam int N_SHORT = 6;
  localparam int N_OPEN = 12;
  localparam int N_EVENTS = N_SHORT + N_OPEN;
  // Field positions inside a status byte.
  localparam int LOW_GROUP_LSB = 0;
  localparam int HIGH_GROUP_LSB = 4;
  localparam int RSVD_LOW_BIT = 3;
  localparam int RSVD_HIGH_BIT = 7;
  // Reset values.
  localparam logic [7:0] FLAG_BYTE_RESET = 8'h00;
  localparam logic [N_EVENTS-1:0] IRQ_MASK_RESET = 18'h00000;
  localparam logic [N_EVENTS-1:0] IRQ_STATUS_RESET = 18'h00000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
  // Input synchroniser depth.
  localparam int SYNC_STAGES = 3;
endpackage

//--- hw/fault_level_if.sv
// Interface carrying filtered fault levels and their rising-edge events.
`timescale 1ns/10ps
interface fault_level_if #(
  parameter int N = 18
);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

//--- hw/fault_sync.sv
// Three-stage synchroniser with agreement filter and rise detect per bit.
`timescale 1ns/10ps
module fault_sync #(
  parameter int N = 18
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Raw detector levels from outside the clock domain.
  input wire logic [N-1:0] raw,
  // Filtered levels and events.
  fault_level_if.src out
);
  logic [N-1:0] s1_q, s2_q, s3_q;
  logic [N-1:0] level_q, level_d;
  logic [N-1:0] rise_q, rise_d;

  always_comb begin
    level_d = level_q;
    rise_d = '0;
    for (int i = 0; i < N; i++) begin
      // A change is taken only once the second and third stages agree.
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
      rise_d[i] = level_d[i] & ~level_q[i];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
      rise_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign out.level = level_q;
  assign out.rise = rise_q;
endmodule

//--- hw/fault_irq.sv
// Sticky interrupt status with read clear, mask gating and level output.
`timescale 1ns/10ps
module fault_irq #(
  parameter int N = 18
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Events, mask and read-clear strobe.
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] mask,
  input wire logic clear,
  // State and interrupt.
  output logic [N-1:0] status_q,
  output logic irq_q
);
  logic [N-1:0] status_d;
  logic irq_d;

  always_comb begin
    // A set in the clearing cycle survives the clear.
    status_d = (clear ? '0 : status_q) | set;
    irq_d = |(status_d & mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_q <= fault_flags_pkg::IRQ_STATUS_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end
endmodule

//--- tb/led_fault_status_flags_checker.sv
// Port checks of the fault flag register bank.
`timescale 1ns/10ps
module led_fault_status_flags_checker (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Bus and detectors.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] short_detect,
  input wire logic [11:0] open_detect
);
  logic [17:0] p_q;
  logic [3:0] n_q;
  logic rd;
  logic fl;
  assign rd = pready && !pwrite;
  assign fl = paddr == 12'h298 || paddr == 12'h29C || paddr == 12'h2A0;
  function automatic logic [31:0] fb(input logic [5:0] x);
    return {25'h0, x[5:3], 1'b0, x[2:0]};
  endfunction
  // Counts cycles since the detectors last moved, so reads are settled.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p_q <= 18'h00000;
      n_q <= 4'h0;
    end else begin
      p_q <= {open_detect, short_detect};
      n_q <= (p_q != {open_detect, short_detect}) ? 4'h0 :
        n_q + {3'h0, n_q != 4'hF};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence done_s;
    pready ##1 !pready;
  endsequence
  a_one_wait: assert property (acc_s |=> done_s)
    else $error("bad answer timing");
  a_short_map: assert property (rd && paddr == 12'h298 && n_q > 4'h7
    |-> prdata == fb(short_detect)) else $error("short byte wrong");
  a_ab_map: assert property (rd && paddr == 12'h29C && n_q > 4'h7
    |-> prdata == fb(open_detect[5:0])) else $error("ab byte wrong");
  a_cd_map: assert property (rd && paddr == 12'h2A0 && n_q > 4'h7
    |-> prdata == fb(open_detect[11:6])) else $error("cd byte wrong");
  a_rsvd_zero: assert property (rd && fl
    |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3] && !pslverr)
    else $error("reserved bits set");
  a_write_quiet: assert property (pready && pwrite && fl
    |-> prdata == 32'h0 && !pslverr) else $error("write answer wrong");
  a_unmapped_err: assert property (pready && paddr < 12'h298
    |-> pslverr && prdata == 32'h0) else $error("no error on hole");
  a_live_flag: assert property (rd && paddr == 12'h29C && n_q > 4'h7
    && open_detect[5:0] == 6'h00 |-> prdata[7:0] == 8'h00)
    else $error("open flag without fault");
endmodule

//--- tb/led_fault_status_flags_tb_top.sv
// Self-checking bench of the fault flag register bank.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module led_fault_status_flags_tb_top;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr, open_detect;
  logic [31:0] pwdata, prdata;
  logic [5:0] short_detect;
  logic [32:0] exp_q[$];
  logic [32:0] e_m;
  logic [17:0] v;
  int bad_count, total_checks, cyc;
  led_fault_status_flags u_led_fault_status_flags (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .short_detect(short_detect), .open_detect(open_detect), .irq(irq));
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [32:0] fb(input logic [5:0] x);
    return {26'h0, x[5:3], 1'b0, x[2:0]};
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd3(input logic [17:0] d);
    xfer(0, 12'h298, 0, fb(d[5:0]));
    xfer(0, 12'h29C, 0, fb(d[11:6]));
    xfer(0, 12'h2A0, 0, fb(d[17:12]));
  endtask
  task automatic det(input logic [17:0] d);
    {open_detect, short_detect} <= d;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
  endtask
  always @(negedge mclk) begin
    if (pready === 1'b1) begin
      e_m = exp_q.pop_front();
      `CHK("apb answer", e_m, {pslverr, prdata})
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {short_detect, open_detect} = '0;
    rst = 1;
    void'($urandom(32'h14725533));
    repeat (8) @(posedge mclk);
    rst <= 0;
    rd3(18'h00000);
    $display("reset test done");
    xfer(1, 12'h2C4, 32'h0003FFFF, 33'h0);
    v = 18'($urandom) | 18'h00001;
    det(v);
    `CHK("irq raised", 1'b1, irq)
    xfer(0, 12'h2C0, 0, {15'h0, v});
    @(negedge mclk);
    `CHK("irq cleared", 1'b0, irq)
    xfer(1, 12'h2C4, 0, 33'h0);
    det(0);
    det(v);
    `CHK("irq masked", 1'b0, irq)
    $display("irq test done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 18'h3FFFF : 18'($urandom);
      det(v);
      rd3(v);
    end
    $display("flag map test done");
    for (int i = 0; i < 3; i++) begin
      xfer(1, 12'h298 + 12'(4 * i), $urandom, 33'h0);
    end
    rd3(v);
    xfer(0, 12'h000, 0, {1'b1, 32'h0});
    $display("write and hole test done");
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule
bind led_fault_status_flags led_fault_status_flags_checker
  u_led_fault_status_flags_checker (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .short_detect(short_detect),
  .open_detect(open_detect));
